//--- scc_pkg.sv
// Package for the converter control block: register offsets, fields, timing.
// Assumes an 8-bit special register bus on a single 250 MHz clock.
`default_nettype none
package scc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SCC_MODE_ADDR = 8'hc8;
  localparam logic [7:0] SCC_RESULT_HIGH_ADDR = 8'hc9;
  localparam logic [7:0] SCC_RATE_ADDR = 8'hca;
  localparam logic [7:0] SCC_IRQ_CTRL_ADDR = 8'hcb;
  // ----------------------------------------
  // Mode register fields
  // ----------------------------------------
  localparam int SCC_ENABLE_BIT = 7;
  localparam int SCC_START_BIT = 6;
  localparam int SCC_END_BIT = 5;
  localparam int SCC_GLOBAL_CH_BIT = 4;
  localparam int SCC_CHANNEL_MSB = 3;
  localparam logic [7:0] SCC_MODE_RESET = 8'h00;
  localparam logic [3:0] SCC_LAST_CHANNEL = 4'hb;
  // ----------------------------------------
  // Rate register fields
  // ----------------------------------------
  localparam int SCC_CLKSEL_HI_BIT = 6;
  localparam int SCC_RESOLUTION_BIT = 5;
  localparam int SCC_CLKSEL_LO_BIT = 4;
  localparam logic [2:0] SCC_RATE_RESET = 3'h0;
  // ----------------------------------------
  // Interrupt control register fields
  // ----------------------------------------
  localparam int SCC_IRQ_FLAG_BIT = 0;
  localparam int SCC_IRQ_EN_BIT = 1;
  localparam logic [15:0] SCC_IRQ_VECTOR = 16'h0010;
  // ----------------------------------------
  // Timing: periods of conversion clock / 4
  // ----------------------------------------
  localparam logic [5:0] SCC_PERIODS_10BIT = 6'h0e;
  localparam logic [5:0] SCC_PERIODS_8BIT = 6'h0c;
  localparam logic [9:0] SCC_CLKS_PER_PERIOD = 10'h004;
  localparam logic [9:0] SCC_CLKS_10BIT = 10'(SCC_PERIODS_10BIT * SCC_CLKS_PER_PERIOD);
  localparam logic [9:0] SCC_CLKS_8BIT = 10'(SCC_PERIODS_8BIT * SCC_CLKS_PER_PERIOD);
  localparam logic [4:0] SCC_DIV_16 = 5'h10;
  localparam logic [4:0] SCC_DIV_8 = 5'h08;
  localparam logic [4:0] SCC_DIV_1 = 5'h01;
  localparam logic [4:0] SCC_DIV_2 = 5'h02;

  typedef enum logic [1:0]
  {
    SCC_IDLE = 2'b00,
    SCC_CONVERT = 2'b01
  } scc_state_t;
endpackage
`default_nettype wire

//--- scc_converter.sv
// Converter control: mode, rate and result registers, conversion timer.
// Assumes an analog sampler outside that presents a 10-bit code to latch.
//
// Chosen here: strobed register access.
`default_nettype none
// Notes on behaviour
// - Enable plus start begins a conversion
// - Finish sets end flag, request flag, result
// - Enabled request drives interrupt toward vector 0010H
// - Mode register layout, resets to zero
// - Start bit clears itself at finish
// - End flag low while converting, high after
// - Global enable connects selected channel only
// - Channel codes 0 to 11, rest reserved
// - Rate register layout with low result bits
// - Clock select divides CPU clock 16/8/1/2
// - Resolution bit selects 8 or 10 bits
// - High byte holds result bits 9 to 2
// - 8-bit result fills high byte only
// - Duration counted from start to end flag
// - Ten-bit conversion takes 56 conversion clocks
// - Eight-bit conversion takes 48 conversion clocks
// - Result is straight binary of input
module scc_converter
  import scc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [9:0] sample_code,
  output logic [11:0] analog_inputs_connect,
  output logic converter_powered,
  output logic sample_strobe,
  output logic converter_irq,
  output logic [15:0] irq_vector
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] divider_of(input logic [1:0] sel);
    // Select values map to fixed CPU clock divisors
    if (sel == 2'b00)
      divider_of = SCC_DIV_16;
    else if (sel == 2'b01)
      divider_of = SCC_DIV_8;
    else if (sel == 2'b10)
      divider_of = SCC_DIV_1;
    else
      divider_of = SCC_DIV_2;
  endfunction

  logic enable_q;
  logic start_q;
  logic end_q;
  logic global_ch_q;
  logic [3:0] channel_q;
  logic [1:0] clksel_q;
  logic resolution_q;
  logic irq_flag_q;
  logic irq_en_q;
  logic [9:0] result_q;
  logic [4:0] prescale_q;
  logic [9:0] conv_count_q;
  scc_state_t state_q;
  logic conv_tick;
  logic finish;
  logic begin_conv;
  logic [9:0] conv_target;
  logic wr_mode;
  logic wr_rate;
  logic wr_irq;

  assign wr_mode = reg_write && (reg_addr == SCC_MODE_ADDR);
  assign wr_rate = reg_write && (reg_addr == SCC_RATE_ADDR);
  assign wr_irq = reg_write && (reg_addr == SCC_IRQ_CTRL_ADDR);

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  // start condition
  assign begin_conv = (state_q == SCC_IDLE) && enable_q && start_q;

  assign conv_target = resolution_q ? SCC_CLKS_10BIT : SCC_CLKS_8BIT;

  assign conv_tick = (prescale_q == 5'(divider_of(clksel_q) - 5'h01));

  // counted from start bit to end flag
  assign finish = (state_q == SCC_CONVERT) && conv_tick && (conv_count_q == 10'(conv_target - 10'h001));

  // timing runs from the cycle start is taken
  // Counting in that cycle too keeps the end flag on the exact count
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prescale_q <= 5'h00;
    else if ((state_q != SCC_CONVERT && !begin_conv) || conv_tick)
      prescale_q <= 5'h00;
    else
      prescale_q <= 5'(prescale_q + 5'h01);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      conv_count_q <= 10'h000;
    else if (state_q != SCC_CONVERT && !begin_conv)
      conv_count_q <= 10'h000;
    else if (conv_tick)
      conv_count_q <= 10'(conv_count_q + 10'h001);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= SCC_IDLE;
    else
    begin
      case (state_q)
        SCC_IDLE:
          if (begin_conv)
            state_q <= SCC_CONVERT;
        SCC_CONVERT:
          // Dropping enable aborts: no flags, no result
          if (finish || !enable_q)
            state_q <= SCC_IDLE;
        default:
          state_q <= SCC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  // mode fields and reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_q <= SCC_MODE_RESET[SCC_ENABLE_BIT];
      global_ch_q <= SCC_MODE_RESET[SCC_GLOBAL_CH_BIT];
      channel_q <= SCC_MODE_RESET[SCC_CHANNEL_MSB:0];
    end
    else if (wr_mode)
    begin
      enable_q <= reg_wdata[SCC_ENABLE_BIT];
      global_ch_q <= reg_wdata[SCC_GLOBAL_CH_BIT];
      channel_q <= reg_wdata[SCC_CHANNEL_MSB:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      start_q <= SCC_MODE_RESET[SCC_START_BIT];
    else if (finish || (state_q == SCC_CONVERT && !enable_q))
      start_q <= 1'b0;
    else if (wr_mode)
      start_q <= reg_wdata[SCC_START_BIT];
  end

  // end flag, set wins over write
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      end_q <= SCC_MODE_RESET[SCC_END_BIT];
    else if (finish)
      end_q <= 1'b1;
    else if (begin_conv)
      end_q <= 1'b0;
    else if (wr_mode)
      end_q <= reg_wdata[SCC_END_BIT];
  end

  // ----------------------------------------
  // Rate register
  // ----------------------------------------
  // rate fields
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clksel_q <= SCC_RATE_RESET[1:0];
      resolution_q <= SCC_RATE_RESET[2];
    end
    else if (wr_rate)
    begin
      clksel_q <= {reg_wdata[SCC_CLKSEL_HI_BIT], reg_wdata[SCC_CLKSEL_LO_BIT]};
      resolution_q <= reg_wdata[SCC_RESOLUTION_BIT];
    end
  end

  // ----------------------------------------
  // Interrupt request and enable
  // ----------------------------------------
  // request flag set
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq_flag_q <= 1'b0;
    else if (finish)
      irq_flag_q <= 1'b1;
    else if (wr_irq)
      irq_flag_q <= reg_wdata[SCC_IRQ_FLAG_BIT];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq_en_q <= 1'b0;
    else if (wr_irq)
      irq_en_q <= reg_wdata[SCC_IRQ_EN_BIT];
  end

  assign converter_irq = irq_flag_q && irq_en_q;
  assign irq_vector = SCC_IRQ_VECTOR;

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  // Undefined after reset in spirit; zero keeps simulation clean
  // result latched at finish
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      result_q <= 10'h000;
    else if (finish)
      result_q <= resolution_q ? sample_code : {sample_code[9:2], 2'b00};
  end

  assign sample_strobe = finish;
  assign converter_powered = enable_q;

  // ----------------------------------------
  // Channel connection
  // ----------------------------------------
  // global channel gate
  always_comb
  begin
    analog_inputs_connect = 12'h000;
    if (global_ch_q && channel_q <= SCC_LAST_CHANNEL)
      analog_inputs_connect[channel_q] = 1'b1;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // high byte and low bits
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (!reg_read)
      reg_rdata <= 8'h00;
    else if (reg_addr == SCC_MODE_ADDR)
      reg_rdata <= {enable_q, start_q, end_q, global_ch_q, channel_q};
    else if (reg_addr == SCC_RESULT_HIGH_ADDR)
      reg_rdata <= result_q[9:2];
    else if (reg_addr == SCC_RATE_ADDR)
      reg_rdata <= {1'b0, clksel_q[1], resolution_q, clksel_q[0], 2'b00, result_q[1:0]};
    else if (reg_addr == SCC_IRQ_CTRL_ADDR)
      reg_rdata <= {6'h00, irq_en_q, irq_flag_q};
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_started;
    $rose(state_q == SCC_CONVERT);
  endsequence

  // Enable and start both standing marks a conversion start
  sequence s_start_set;
    $rose(enable_q && start_q);
  endsequence

  // Cycles since start, for lengths beyond a plain delay
  logic [10:0] span_q;
  logic [10:0] span_expect;

  assign span_expect = 11'(conv_target) * 11'(divider_of(clksel_q));

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      span_q <= 11'h000;
    else if (begin_conv)
      span_q <= 11'h001;
    else if (state_q == SCC_CONVERT)
      span_q <= 11'(span_q + 11'h001);
  end

  a_start_begins: assert property (@(posedge clock) disable iff (!reset_n)
    (enable_q && start_q && state_q == SCC_IDLE) |=> state_q == SCC_CONVERT)
    else $error("conversion did not begin");

  a_finish_flags: assert property (@(posedge clock) disable iff (!reset_n)
    finish |=> end_q && irq_flag_q && !start_q)
    else $error("finish flags not set");

  a_irq_output: assert property (@(posedge clock) disable iff (!reset_n)
    (finish && irq_en_q && !wr_irq) |=> converter_irq && irq_vector == SCC_IRQ_VECTOR)
    else $error("interrupt output wrong");

  a_end_low_run: assert property (@(posedge clock) disable iff (!reset_n)
    s_started |-> !end_q)
    else $error("end flag high while converting");

  a_len_ten: assert property (@(posedge clock) disable iff (!reset_n)
    (s_start_set and (resolution_q && clksel_q == 2'b10)) |-> ##55 !end_q ##1 end_q)
    else $error("ten-bit length wrong");

  a_len_eight: assert property (@(posedge clock) disable iff (!reset_n)
    (s_start_set and (!resolution_q && clksel_q == 2'b10)) |-> ##47 !end_q ##1 end_q)
    else $error("eight-bit length wrong");

  a_disabled_ignore: assert property (@(posedge clock) disable iff (!reset_n)
    (!enable_q && state_q == SCC_IDLE) |=> state_q == SCC_IDLE)
    else $error("start taken while disabled");

  a_channel_gate: assert property (@(posedge clock) disable iff (!reset_n)
    !global_ch_q |-> analog_inputs_connect == 12'h000)
    else $error("channel connected while disabled");

  a_eight_low_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (finish && !resolution_q) |=> result_q[1:0] == 2'b00)
    else $error("eight-bit low bits not zero");

  a_len_any: assert property (@(posedge clock) disable iff (!reset_n)
    finish |=> span_q == $past(span_expect))
    else $error("conversion length wrong");

  a_result_high: assert property (@(posedge clock) disable iff (!reset_n)
    finish |=> result_q[9:2] == $past(sample_code[9:2]))
    else $error("high result byte not latched");

  a_ten_low_bits: assert property (@(posedge clock) disable iff (!reset_n)
    (finish && resolution_q) |=> result_q[1:0] == $past(sample_code[1:0]))
    else $error("ten-bit low bits not latched");

  a_abort_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SCC_CONVERT && !enable_q && !finish && !wr_irq) |=>
      (state_q == SCC_IDLE && !start_q && $stable(irq_flag_q)))
    else $error("abort left conversion running");

  a_one_channel: assert property (@(posedge clock) disable iff (!reset_n)
    (global_ch_q && channel_q <= SCC_LAST_CHANNEL) |-> $onehot(analog_inputs_connect))
    else $error("selected channel not alone");

  a_reserved_none: assert property (@(posedge clock) disable iff (!reset_n)
    (channel_q > SCC_LAST_CHANNEL) |-> analog_inputs_connect == 12'h000)
    else $error("reserved code connected a channel");

endmodule
`default_nettype wire

//--- scc_analog_model.sv
// Stand-in for the analog inputs and the sampler code they produce.
// Assumes the converter drives a one-hot channel connect vector.
`default_nettype none
module scc_analog_model
(
  input wire logic clock,
  input wire logic [11:0] connect,
  output logic [9:0] code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] idle_q = 10'h155;
  // ----------------------------------------
  // Channel levels
  // ----------------------------------------
  // Floating input toggles so no stale code is latched
  always @(posedge clock)
  begin
    idle_q <= ~idle_q;
  end
  always_comb
  begin
    code = idle_q;
    for (int i = 0; i < 12; i++)
    begin
      if (connect[i])
      begin
        code = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'(i * 91);
      end
    end
  end
endmodule
`default_nettype wire

//--- sar_converter_control_tb.sv
// Self-checking bench for the converter control block.
// Assumes the analog model answers on the selected channel.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module sar_converter_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;
  logic clock, reset_n, reg_write, reg_read, sample_strobe, converter_irq, converter_powered;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [9:0] sample_code;
  logic [11:0] analog_inputs_connect;
  logic [15:0] irq_vector;
  int miscompares = 0;
  int checks_done = 0;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  scc_converter scc_converter_i (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_code(sample_code), .analog_inputs_connect(analog_inputs_connect),
    .converter_powered(converter_powered), .sample_strobe(sample_strobe),
    .converter_irq(converter_irq), .irq_vector(irq_vector));
  scc_analog_model scc_analog_model_i (.clock(clock), .connect(analog_inputs_connect),
    .code(sample_code));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    `CHK(reg_rdata, e)
  endtask
  task automatic gate(input logic [7:0] m, input logic [11:0] e);
    wr(SCC_MODE_ADDR, m);
    @(negedge clock);
    `CHK(analog_inputs_connect, e)
  endtask
  function automatic int dv(input logic [1:0] s);
    return s == 2'h0 ? 16 : s == 2'h1 ? 8 : s == 2'h2 ? 1 : 2;
  endfunction
  // Long conversions dominate run time, so each mode runs once
  task automatic conv(input logic [3:0] ch, input logic [1:0] sel, input logic r);
    int n;
    logic [9:0] c;
    c = ch == 0 ? 10'h000 : ch == 1 ? 10'h3ff : 10'(ch * 7'h5b);
    wr(SCC_RATE_ADDR, {1'b0, sel[1], r, sel[0], 4'h0});
    wr(SCC_IRQ_CTRL_ADDR, 8'h02);
    gate({4'hd, ch}, 12'h001 << ch);
    n = 1;
    while (sample_strobe !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(n, (r ? 56 : 48) * dv(sel))
    @(negedge clock);
    `CHK(converter_irq, 1'b1)
    `CHK(irq_vector, 16'h0010)
    rd(SCC_MODE_ADDR, {4'hb, ch});
    rd(SCC_RESULT_HIGH_ADDR, c[9:2]);
    rd(SCC_RATE_ADDR, {1'b0, sel[1], r, sel[0], 2'b00, r ? c[1:0] : 2'b00});
    wr(SCC_IRQ_CTRL_ADDR, 8'h02);
    @(negedge clock);
    `CHK(converter_irq, 1'b0)
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    #40000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(SCC_MODE_ADDR, 8'h00);
    rd(SCC_RATE_ADDR, 8'h00);
    rd(8'hc0, 8'h00);
    `CHK(converter_powered, 1'b0)
    gate(8'h0b, 12'h000);
    gate(8'h1b, 12'h800);
    gate(8'h1c, 12'h000);
    wr(SCC_RATE_ADDR, 8'h40);
    wr(SCC_MODE_ADDR, 8'h40);
    repeat (100)
    begin
      @(negedge clock);
      `CHK(sample_strobe, 1'b0)
    end
    rd(SCC_MODE_ADDR, 8'h40);
    rd(SCC_IRQ_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      conv(4'(k), 2'(k), k >= 4);
      `CHK(converter_powered, 1'b1)
    end
    // Clearing enable mid-run aborts with no flags
    gate(8'hd1, 12'h002);
    wr(SCC_MODE_ADDR, 8'h51);
    repeat (120)
    begin
      @(negedge clock);
      `CHK(sample_strobe, 1'b0)
    end
    rd(SCC_MODE_ADDR, 8'h11);
    rd(SCC_IRQ_CTRL_ADDR, 8'h02);
    rd(SCC_RESULT_HIGH_ADDR, 8'h9f);
    stop_test();
  end
endmodule
`default_nettype wire
